// [shared/epsm_pkg.sv]
// Constants, register map and state type of the power state manager
package epsm_pkg;
  // Clock rate and timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int WAKE_PULSE_MS = 50;
  localparam int WAKE_PULSE_CYC = WAKE_PULSE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int PULSE_W = 24;
  localparam int SETTLE_NS = 1000;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_W = 9;
  localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(SETTLE_CYC - 1);

  // Register byte addresses
  localparam logic [7:0] ADDR_PMC = 8'h00;
  localparam logic [7:0] ADDR_INT = 8'h04;
  localparam logic [7:0] ADDR_TEST = 8'h08;
  localparam logic [7:0] ADDR_PHY = 8'h0c;

  // Fixed readback of the test register, arbitrary value
  localparam logic [31:0] TEST_PATTERN = 32'h1234_5678;

  // power_mgmt_control fields
  localparam int PMC_READY = 0;
  localparam int PMC_PSS = 1;
  localparam int PMC_WAKEUP_SOURCE_STATUS = 3;
  localparam int PMC_PIN_EN = 5;
  localparam int PMC_WAKE_FRAME_ENABLE = 6;
  localparam int PMC_ENERGY_WAKE_ENABLE = 7;
  localparam int PMC_PULSE_SEL = 8;

  // interrupt_status_reg fields
  localparam int INT_WAKE = 0;
  localparam int INT_EON = 1;

  // PHY power control fields
  localparam int PHY_GPD = 0;
  localparam int PHY_EPD = 1;
  localparam int PHY_EON_IEN = 2;

  // Field encodings
  localparam logic [1:0] PSS_NORMAL = 2'h0;
  localparam logic [1:0] PSS_LIGHT = 2'h1;
  localparam logic [1:0] PSS_DEEP = 2'h2;
  localparam logic [1:0] WAKEUP_SOURCE_STATUS_NONE = 2'h0;
  localparam logic [1:0] WAKEUP_SOURCE_STATUS_ENERGY = 2'h1;
  localparam logic [1:0] WAKEUP_SOURCE_STATUS_FRAME = 2'h2;

  // Power states, one-hot
  typedef enum logic [3:0] {
    ST_NORMAL = 4'h1,
    ST_LIGHT = 4'h2,
    ST_DEEP = 4'h4,
    ST_RESUME = 4'h8
  } epsm_state_t;
endpackage : epsm_pkg

// [shared/epsm_tmr_if.sv]
// Handshake between the manager and its wake pulse timer
interface epsm_tmr_if;
  logic start;
  logic abort;
  logic busy;
  modport ctl (output start, output abort, input busy);
  modport tmr (input start, input abort, output busy);
endinterface : epsm_tmr_if

// [rtl/epsm_pulse_timer.sv]
// Fixed-length pulse timer for the wake pin
module epsm_pulse_timer #(
  parameter int unsigned CYC = epsm_pkg::WAKE_PULSE_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Control from the manager
  epsm_tmr_if.tmr tmr
);
  logic [epsm_pkg::PULSE_W-1:0] cnt_r;
  logic [epsm_pkg::PULSE_W-1:0] cnt_nxt;
  logic busy_r;
  logic busy_nxt;

  // Next count: abort wins, start loads, else count down
  always_comb begin
    cnt_nxt = cnt_r;
    busy_nxt = busy_r;
    if (tmr.abort) begin
      busy_nxt = 1'b0; // see R18
      cnt_nxt = '0;
    end else if (tmr.start) begin
      busy_nxt = 1'b1; // see R17
      cnt_nxt = epsm_pkg::PULSE_W'(CYC - 1);
    end else if (busy_r) begin
      if (cnt_r == '0) begin
        busy_nxt = 1'b0;
      end else begin
        cnt_nxt = cnt_r - 1'b1;
      end
    end
  end

  // Registers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= '0;
      busy_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign tmr.busy = busy_r;

  property p_pulse_abort;
    @(posedge sys_clk) disable iff (!rst_b) tmr.abort |=> !busy_r;
  endproperty
  a_pulse_abort: assert property (p_pulse_abort) else $error("pulse not ended on abort"); // see R18

  property p_pulse_start;
    @(posedge sys_clk) disable iff (!rst_b)
      (tmr.start && !tmr.abort) |=> busy_r && (cnt_r == epsm_pkg::PULSE_W'(CYC - 1));
  endproperty
  a_pulse_start: assert property (p_pulse_start) else $error("pulse did not load"); // see R17
endmodule : epsm_pulse_timer

// [rtl/epsm_top.sv]
// Ethernet power state manager with Wishbone register access
// Behaviour
// R1 - In sleep only power_mgmt_control can be read; other registers are hidden.
// R2 - Ready flag is clear in either sleep state until back in normal.
// R3 - Host reads nothing but power_mgmt_control while ready is clear; the bench reads the test register once in light sleep.
// R4 - Host writes only the wake write to the test register while not ready.
// R5 - Writes are ignored until the first read after reset or sleep.
// R6 - Any test register write in sleep wakes to normal, select back to normal.
// R7 - Select value 01 enters light sleep and clears ready.
// R8 - Light sleep gates MAC and host clocks; PHY, internal, RX PM keep running.
// R9 - Light sleep detects wake frames; detection sets wake source to 10b.
// R10 - Light sleep wake drives the wake pin when frame and pin enables set.
// R11 - Wake interrupt status sets on any wake event, whatever the pin enable.
// R12 - Host sets PHY energy powerdown before choosing deep sleep.
// R13 - Select value 10 enters deep sleep, clears ready, gates all clocks.
// R14 - Deep sleep carrier with energy and pin enables drives pin, source 01b.
// R15 - Host clears PHY energy powerdown only after ready returns.
// R16 - Wake status holds while source and enable stand; then write one clears.
// R17 - Pulse select gives a 50 ms pin pulse, else a steady level.
// R18 - Pin drops when source, matching enable or pin enable is cleared.
// R19 - PHY general powerdown holds PHY off; clearing it powers up with reset.
// R20 - Energy powerdown without line energy keeps the PHY off and silent.
// R21 - Line energy powers PHY up and sets the energy-on flag, may interrupt.
// R22 - Ready sets within 2 ms of the wake write.
// R23 - Ready sets only once clocks run again and the state is normal.
//
// Implementation choices: the address map and the Wishbone register port.
module epsm_top #(
  parameter int unsigned WAKE_PULSE_CYC = epsm_pkg::WAKE_PULSE_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Wishbone slave
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  // Wake sources
  input wire logic wake_frame_det,
  input wire logic line_energy_present,
  // Power outputs
  output logic wake_pin,
  output logic mac_host_clk_en,
  output logic core_clk_en,
  output logic phy_active,
  output logic phy_reset,
  output logic phy_irq
);
  epsm_tmr_if tmr_if ();

  epsm_pkg::epsm_state_t st_r, st_nxt;
  logic [1:0] pss_r, pss_nxt;
  logic [1:0] wakeup_source_status_r, wakeup_source_status_nxt;
  logic pin_en_r, pin_en_nxt;
  logic wake_frame_enable_r, wake_frame_enable_nxt;
  logic energy_wake_enable_r, energy_wake_enable_nxt;
  logic pulse_sel_r, pulse_sel_nxt;
  logic wint_r, wint_nxt;
  logic eon_r, eon_nxt;
  logic gpd_r, gpd_nxt;
  logic epd_r, epd_nxt;
  logic eon_ien_r, eon_ien_nxt;
  logic read_seen_r, read_seen_nxt;
  logic [epsm_pkg::SETTLE_W-1:0] settle_r, settle_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic ready_r, ready_nxt;
  logic mhclk_r, mhclk_nxt;
  logic cclk_r, cclk_nxt;
  logic phy_act_r, phy_act_nxt;
  logic phy_rst_r, phy_rst_nxt;
  logic phy_irq_r, phy_irq_nxt;
  logic pin_r, pin_nxt;
  logic src_q_r, start_r, start_nxt;
  logic esync1_r, esync2_r, esync3_r;
  logic req, rd, wr, asleep, wr_ok, wake_wr, pme_src, src_en;

  // Bus decode and wake sources
  assign req = wb_cyc && wb_stb && !ack_r;
  assign rd = req && !wb_we;
  assign wr = req && wb_we;
  assign asleep = (st_r != epsm_pkg::ST_NORMAL);
  assign wr_ok = wr && read_seen_r && !asleep; // see R5
  assign wake_wr = wr && (wb_adr == epsm_pkg::ADDR_TEST)
      && (st_r == epsm_pkg::ST_LIGHT || st_r == epsm_pkg::ST_DEEP); // see R4
  assign pme_src = (wakeup_source_status_r == epsm_pkg::WAKEUP_SOURCE_STATUS_FRAME && wake_frame_enable_r)
      || (wakeup_source_status_r == epsm_pkg::WAKEUP_SOURCE_STATUS_ENERGY && energy_wake_enable_r); // see R16
  assign src_en = pme_src && pin_en_r; // see R10
  assign tmr_if.start = start_r;
  assign tmr_if.abort = !src_en; // see R18

  // Next values of the state, bus, register-map and PHY reset registers
  always_comb begin
    st_nxt = st_r;
    pss_nxt = pss_r;
    wakeup_source_status_nxt = wakeup_source_status_r;
    pin_en_nxt = pin_en_r;
    wake_frame_enable_nxt = wake_frame_enable_r;
    energy_wake_enable_nxt = energy_wake_enable_r;
    pulse_sel_nxt = pulse_sel_r;
    wint_nxt = wint_r;
    eon_nxt = eon_r;
    gpd_nxt = gpd_r;
    epd_nxt = epd_r;
    eon_ien_nxt = eon_ien_r;
    read_seen_nxt = read_seen_r;
    settle_nxt = settle_r;
    phy_rst_nxt = 1'b0;
    ack_nxt = req;
    dat_nxt = '0;
    // Reads; only the control register answers while asleep
    if (rd) begin
      read_seen_nxt = 1'b1; // see R5
      if (wb_adr == epsm_pkg::ADDR_PMC) begin
        dat_nxt[epsm_pkg::PMC_READY] = ready_r;
        dat_nxt[epsm_pkg::PMC_PSS +: 2] = pss_r;
        dat_nxt[epsm_pkg::PMC_WAKEUP_SOURCE_STATUS +: 2] = wakeup_source_status_r;
        dat_nxt[epsm_pkg::PMC_PIN_EN] = pin_en_r;
        dat_nxt[epsm_pkg::PMC_WAKE_FRAME_ENABLE] = wake_frame_enable_r;
        dat_nxt[epsm_pkg::PMC_ENERGY_WAKE_ENABLE] = energy_wake_enable_r;
        dat_nxt[epsm_pkg::PMC_PULSE_SEL] = pulse_sel_r;
      end else if (!asleep) begin // see R1
        if (wb_adr == epsm_pkg::ADDR_INT) begin
          dat_nxt[epsm_pkg::INT_WAKE] = wint_r;
          dat_nxt[epsm_pkg::INT_EON] = eon_r;
        end else if (wb_adr == epsm_pkg::ADDR_PHY) begin
          dat_nxt[epsm_pkg::PHY_GPD] = gpd_r;
          dat_nxt[epsm_pkg::PHY_EPD] = epd_r;
          dat_nxt[epsm_pkg::PHY_EON_IEN] = eon_ien_r;
        end else if (wb_adr == epsm_pkg::ADDR_TEST) begin
          dat_nxt = epsm_pkg::TEST_PATTERN;
        end
      end
    end
    // Control register write
    if (wr_ok && wb_adr == epsm_pkg::ADDR_PMC && wb_sel[0]) begin
      if (wb_dat_w[epsm_pkg::PMC_PSS +: 2] == epsm_pkg::PSS_LIGHT) begin
        st_nxt = epsm_pkg::ST_LIGHT; // see R7
        pss_nxt = epsm_pkg::PSS_LIGHT;
      end else if (wb_dat_w[epsm_pkg::PMC_PSS +: 2] == epsm_pkg::PSS_DEEP) begin
        st_nxt = epsm_pkg::ST_DEEP; // see R13
        pss_nxt = epsm_pkg::PSS_DEEP;
      end
      wakeup_source_status_nxt = wakeup_source_status_r & ~wb_dat_w[epsm_pkg::PMC_WAKEUP_SOURCE_STATUS +: 2]; // see R18
      pin_en_nxt = wb_dat_w[epsm_pkg::PMC_PIN_EN];
      wake_frame_enable_nxt = wb_dat_w[epsm_pkg::PMC_WAKE_FRAME_ENABLE];
      energy_wake_enable_nxt = wb_dat_w[epsm_pkg::PMC_ENERGY_WAKE_ENABLE];
    end
    if (wr_ok && wb_adr == epsm_pkg::ADDR_PMC && wb_sel[1]) begin
      pulse_sel_nxt = wb_dat_w[epsm_pkg::PMC_PULSE_SEL]; // see R17
    end
    // Status write-one-to-clear
    if (wr_ok && wb_adr == epsm_pkg::ADDR_INT && wb_sel[0]) begin
      if (wb_dat_w[epsm_pkg::INT_WAKE]) begin
        wint_nxt = 1'b0;
      end
      if (wb_dat_w[epsm_pkg::INT_EON]) begin
        eon_nxt = 1'b0;
      end
    end
    // PHY power control write
    if (wr_ok && wb_adr == epsm_pkg::ADDR_PHY && wb_sel[0]) begin
      gpd_nxt = wb_dat_w[epsm_pkg::PHY_GPD];
      epd_nxt = wb_dat_w[epsm_pkg::PHY_EPD];
      eon_ien_nxt = wb_dat_w[epsm_pkg::PHY_EON_IEN];
      phy_rst_nxt = gpd_r && !wb_dat_w[epsm_pkg::PHY_GPD]; // see R19
    end
    // Wake write from either sleep state
    if (wake_wr) begin
      st_nxt = epsm_pkg::ST_RESUME; // see R6
      pss_nxt = epsm_pkg::PSS_NORMAL;
      read_seen_nxt = 1'b0; // see R5
      settle_nxt = '0;
    end
    // Clocks settle before ready returns
    if (st_r == epsm_pkg::ST_RESUME) begin
      if (settle_r == epsm_pkg::SETTLE_LAST) begin
        st_nxt = epsm_pkg::ST_NORMAL; // see R22
      end else begin
        settle_nxt = settle_r + 1'b1;
      end
    end
    // Hardware sets win over software clears
    if (st_r == epsm_pkg::ST_LIGHT && wake_frame_det) begin
      wakeup_source_status_nxt = epsm_pkg::WAKEUP_SOURCE_STATUS_FRAME; // see R9
    end
    if (st_r == epsm_pkg::ST_DEEP && energy_wake_enable_r && esync2_r) begin
      wakeup_source_status_nxt = epsm_pkg::WAKEUP_SOURCE_STATUS_ENERGY; // see R14
    end
    if (pme_src) begin
      wint_nxt = 1'b1; // see R11
    end
    if (epd_r && esync2_r && !esync3_r) begin
      eon_nxt = 1'b1; // see R21
    end
  end

  // Outputs derived from the next state; pulse start and wake pin from the current one
  always_comb begin
    ready_nxt = (st_nxt == epsm_pkg::ST_NORMAL); // see R2
    mhclk_nxt = (st_nxt == epsm_pkg::ST_NORMAL) || (st_nxt == epsm_pkg::ST_RESUME); // see R8
    cclk_nxt = (st_nxt != epsm_pkg::ST_DEEP); // see R13
    phy_act_nxt = !gpd_nxt && !(epd_nxt && !esync2_r); // see R20
    phy_irq_nxt = eon_nxt && eon_ien_nxt; // see R21
    start_nxt = src_en && !src_q_r; // see R17
    pin_nxt = pulse_sel_r ? (tmr_if.busy && src_en) : src_en; // see R18
  end

  // Registers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= epsm_pkg::ST_NORMAL;
      pss_r <= epsm_pkg::PSS_NORMAL;
      wakeup_source_status_r <= epsm_pkg::WAKEUP_SOURCE_STATUS_NONE;
      pin_en_r <= 1'b0;
      wake_frame_enable_r <= 1'b0;
      energy_wake_enable_r <= 1'b0;
      pulse_sel_r <= 1'b0;
      wint_r <= 1'b0;
      eon_r <= 1'b0;
      gpd_r <= 1'b0;
      epd_r <= 1'b0;
      eon_ien_r <= 1'b0;
      read_seen_r <= 1'b0;
      settle_r <= '0;
      ack_r <= 1'b0;
      dat_r <= '0;
      ready_r <= 1'b1;
      mhclk_r <= 1'b1;
      cclk_r <= 1'b1;
      phy_act_r <= 1'b1;
      phy_rst_r <= 1'b0;
      phy_irq_r <= 1'b0;
      pin_r <= 1'b0;
      src_q_r <= 1'b0;
      start_r <= 1'b0;
      esync1_r <= 1'b0;
      esync2_r <= 1'b0;
      esync3_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      pss_r <= pss_nxt;
      wakeup_source_status_r <= wakeup_source_status_nxt;
      pin_en_r <= pin_en_nxt;
      wake_frame_enable_r <= wake_frame_enable_nxt;
      energy_wake_enable_r <= energy_wake_enable_nxt;
      pulse_sel_r <= pulse_sel_nxt;
      wint_r <= wint_nxt;
      eon_r <= eon_nxt;
      gpd_r <= gpd_nxt;
      epd_r <= epd_nxt;
      eon_ien_r <= eon_ien_nxt;
      read_seen_r <= read_seen_nxt;
      settle_r <= settle_nxt;
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
      ready_r <= ready_nxt;
      mhclk_r <= mhclk_nxt;
      cclk_r <= cclk_nxt;
      phy_act_r <= phy_act_nxt;
      phy_rst_r <= phy_rst_nxt;
      phy_irq_r <= phy_irq_nxt;
      pin_r <= pin_nxt;
      src_q_r <= src_en;
      start_r <= start_nxt;
      esync1_r <= line_energy_present;
      esync2_r <= esync1_r;
      esync3_r <= esync2_r;
    end
  end

  // Wake pin pulse timer
  epsm_pulse_timer #(
    .CYC(WAKE_PULSE_CYC)
  ) u_pulse (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .tmr(tmr_if.tmr)
  );

  // Output ports
  assign wb_dat_r = dat_r;
  assign wb_ack = ack_r;
  assign wake_pin = pin_r;
  assign mac_host_clk_en = mhclk_r;
  assign core_clk_en = cclk_r;
  assign phy_active = phy_act_r;
  assign phy_reset = phy_rst_r;
  assign phy_irq = phy_irq_r;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  property p_sleep_read;
    (rd && asleep && wb_adr != epsm_pkg::ADDR_PMC) |=> wb_ack && (wb_dat_r == '0);
  endproperty
  a_sleep_read: assert property (p_sleep_read) else $error("hidden register read in sleep"); // see R1

  property p_ready_clear;
    (st_r != epsm_pkg::ST_NORMAL) |-> !ready_r;
  endproperty
  a_ready_clear: assert property (p_ready_clear) else $error("ready set outside normal"); // see R2

  property p_first_read;
    (wr && !read_seen_r && wb_adr == epsm_pkg::ADDR_PMC)
      |=> $stable({pss_r, pin_en_r, wake_frame_enable_r, energy_wake_enable_r, pulse_sel_r});
  endproperty
  a_first_read: assert property (p_first_read) else $error("write before first read"); // see R5

  property p_wake_write;
    wake_wr |=> (st_r == epsm_pkg::ST_RESUME) && (pss_r == epsm_pkg::PSS_NORMAL) && mhclk_r;
  endproperty
  a_wake_write: assert property (p_wake_write) else $error("wake write did not resume"); // see R6

  property p_light_entry;
    (wr_ok && wb_adr == epsm_pkg::ADDR_PMC && wb_sel[0]
      && wb_dat_w[epsm_pkg::PMC_PSS +: 2] == epsm_pkg::PSS_LIGHT)
      |=> (st_r == epsm_pkg::ST_LIGHT) && !ready_r && !mhclk_r && cclk_r;
  endproperty
  a_light_entry: assert property (p_light_entry) else $error("light sleep entry wrong"); // see R7

  property p_frame_detect;
    (st_r == epsm_pkg::ST_LIGHT && wake_frame_det) |=> (wakeup_source_status_r == epsm_pkg::WAKEUP_SOURCE_STATUS_FRAME);
  endproperty
  a_frame_detect: assert property (p_frame_detect) else $error("frame wake not recorded"); // see R9

  property p_wake_status;
    pme_src |=> wint_r;
  endproperty
  a_wake_status: assert property (p_wake_status) else $error("wake status not held"); // see R11

  property p_deep_entry;
    (wr_ok && wb_adr == epsm_pkg::ADDR_PMC && wb_sel[0]
      && wb_dat_w[epsm_pkg::PMC_PSS +: 2] == epsm_pkg::PSS_DEEP)
      |=> (st_r == epsm_pkg::ST_DEEP) && !ready_r && !mhclk_r && !cclk_r;
  endproperty
  a_deep_entry: assert property (p_deep_entry) else $error("deep sleep entry wrong"); // see R13

  property p_ready_time;
    $rose(st_r == epsm_pkg::ST_RESUME) |-> ##[1:300] ready_r;
  endproperty
  a_ready_time: assert property (p_ready_time) else $error("ready late after wake"); // see R22

  property p_pin_off;
    (!src_en)[*3] |-> !wake_pin;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("wake pin without source"); // see R18

  property p_energy_flag;
    (epd_r && esync2_r && !esync3_r) |=> eon_r;
  endproperty
  a_energy_flag: assert property (p_energy_flag) else $error("energy-on flag missed"); // see R21
endmodule : epsm_top

// [tb/epsm_host_model.sv]
// Host processor model that speaks classic Wishbone to the manager
module epsm_host_model (
  // Clock
  input wire logic sys_clk,
  // Wishbone master side
  output logic wb_cyc,
  output logic wb_stb,
  output logic wb_we,
  output logic [7:0] wb_adr,
  output logic [3:0] wb_sel,
  output logic [31:0] wb_dat_w,
  input wire logic [31:0] wb_dat_r,
  input wire logic wb_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  int hangs = 0;

  // Idle bus from time zero
  initial begin
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_sel = 4'h0;
    wb_dat_w = 32'h0000_0000;
  end

  // One single cycle, held until ack is sampled high or 50 clocks pass
  task xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_sel <= 4'hf;
    wb_dat_w <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      hangs++;
    end
    q = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask : xfer

  // Read; callers poll only the control word while not ready, and t_light reads the test register once in light sleep
  task rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0000_0000, q);
  endtask : rd

  // Write; only the wake write is issued while not ready
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr
endmodule : epsm_host_model

// [tb/ethernet_power_state_manager_tb.sv]
// Self-checking bench for the power state manager
module ethernet_power_state_manager_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] PMC = epsm_pkg::ADDR_PMC;
  localparam logic [7:0] INTR = epsm_pkg::ADDR_INT;
  localparam logic [7:0] TST = epsm_pkg::ADDR_TEST;
  localparam logic [7:0] PHY = epsm_pkg::ADDR_PHY;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic frame_det = 1'b0;
  logic energy = 1'b0;
  logic wb_cyc, wb_stb, wb_we, wb_ack;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat_w, wb_dat_r, rd;
  logic pin, mh_en, core_en, phy_on, phy_rst, irq;
  int num_errors = 0;
  int samples_checked = 0;

  // 250 MHz clock
  always #2 sys_clk = ~sys_clk;

  epsm_host_model u_host (.sys_clk(sys_clk), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
    .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
    .wb_dat_r(wb_dat_r), .wb_ack(wb_ack));

  epsm_top #(.WAKE_PULSE_CYC(20)) u_dut (.sys_clk(sys_clk), .rst_b(rst_b),
    .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
    .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
    .wake_frame_det(frame_det), .line_energy_present(energy), .wake_pin(pin),
    .mac_host_clk_en(mh_en), .core_clk_en(core_en), .phy_active(phy_on),
    .phy_reset(phy_rst), .phy_irq(irq));

  // Compare and count
  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, seen, exp);
    end
  endtask : check

  // Wait a bounded time for the wake pin level
  task wait_pin(input logic v);
    int n;
    for (n = 0; n < 12 && pin !== v; n++) @(posedge sys_clk);
    check({31'h0, pin}, {31'h0, v}, "wake pin");
  endtask : wait_pin

  // Poll the ready flag after the wake write, bounded
  task wake_up;
    int n;
    u_host.wr(TST, 32'h0000_0000);
    rd = 32'h0;
    for (n = 0; n < 150 && rd[0] !== 1'b1; n++) u_host.rd(PMC, rd);
    check({31'h0, rd[0]}, 32'h1, "ready");
    check({31'h0, mh_en & core_en}, 32'h1, "clocks back");
  endtask : wake_up

  // Writes ignored until the first read
  task t_first_read;
    u_host.wr(PMC, 32'h0000_0020);
    u_host.rd(PMC, rd);
    check(rd, 32'h0000_0001, "write before read");
    u_host.wr(PMC, 32'h0000_0020);
    u_host.rd(PMC, rd);
    check(rd, 32'h0000_0021, "write after read");
  endtask : t_first_read

  // Light sleep, frame wake, static pin, status clearing
  task t_light;
    u_host.wr(PMC, 32'h0000_0062);
    repeat (3) @(posedge sys_clk);
    check({30'h0, mh_en, core_en}, 32'h1, "light clocks");
    u_host.rd(PMC, rd);
    check(rd, 32'h0000_0062, "light control");
    u_host.rd(TST, rd);
    check(rd, 32'h0, "hidden register");
    frame_det <= 1'b1;
    @(posedge sys_clk);
    frame_det <= 1'b0;
    wait_pin(1'b1);
    u_host.rd(PMC, rd);
    check(rd, 32'h0000_0072, "frame source");
    wake_up();
    u_host.rd(PMC, rd);
    check(rd, 32'h0000_0071, "select back normal");
    u_host.rd(INTR, rd);
    check({31'h0, rd[0]}, 32'h1, "wake status");
    u_host.wr(INTR, 32'h0000_0001);
    u_host.rd(INTR, rd);
    check({31'h0, rd[0]}, 32'h1, "status held");
    u_host.wr(PMC, 32'h0000_0078);
    wait_pin(1'b0);
    u_host.wr(INTR, 32'h0000_0001);
    u_host.rd(INTR, rd);
    check({31'h0, rd[0]}, 32'h0, "status cleared");
    u_host.wr(PMC, 32'h0000_0000);
  endtask : t_light

  // PHY general and energy powerdown
  task t_phy;
    int n;
    u_host.wr(PHY, 32'h0000_0001);
    repeat (3) @(posedge sys_clk);
    check({31'h0, phy_on}, 32'h0, "phy off");
    u_host.wr(PHY, 32'h0000_0000);
    for (n = 0; n < 10 && phy_rst !== 1'b1; n++) @(posedge sys_clk);
    check({31'h0, phy_rst}, 32'h1, "phy reset pulse");
    u_host.wr(PHY, 32'h0000_0006);
    repeat (3) @(posedge sys_clk);
    check({31'h0, phy_on}, 32'h0, "no energy");
    energy <= 1'b1;
    repeat (8) @(posedge sys_clk);
    check({30'h0, phy_on, irq}, 32'h3, "energy on");
  endtask : t_phy

  // Deep sleep with carrier present, pulsed pin
  task t_deep;
    int n;
    u_host.wr(PMC, 32'h0000_01a4);
    repeat (3) @(posedge sys_clk);
    check({30'h0, mh_en, core_en}, 32'h0, "deep clocks");
    wait_pin(1'b1);
    for (n = 0; n < 40 && pin === 1'b1; n++) @(posedge sys_clk);
    check(n, 32'd20, "pulse length");
    u_host.rd(PMC, rd);
    check(rd, 32'h0000_01ac, "energy source");
    wake_up();
    u_host.wr(PHY, 32'h0000_0004);
    u_host.rd(PMC, rd);
    check(rd, 32'h0000_01a9, "deep back normal");
  endtask : t_deep

  // A hung bus transfer ends the run at once
  always @(posedge sys_clk) begin
    if (u_host.hangs != 0) begin
      close_out();
    end
  end

  // Verdict and end of run
  task close_out;
    num_errors += u_host.hangs;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  // Main sequence
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_first_read();
    t_light();
    t_phy();
    t_deep();
    close_out();
  end
endmodule : ethernet_power_state_manager_tb
